/* logic/pswrc_defines.vh */
// pswrc_defines.vh: constants for the power state, wake and reset controller
// assumes: included by the design file by its bare name
`ifndef PSWRC_DEFINES_VH
`define PSWRC_DEFINES_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define PSWRC_ADDR_CTRL      8'h00
`define PSWRC_ADDR_STAT      8'h01
`define PSWRC_ADDR_SBY_SEL   8'h02
`define PSWRC_ADDR_SEN_EN    8'h03
`define PSWRC_ADDR_TOUCH     8'h04
// ----------------------------------------
// control register fields
// ----------------------------------------
`define PSWRC_CTRL_LP_BIT    0
`define PSWRC_CTRL_DS_BIT    1
`define PSWRC_CTRL_INT_BIT   2
`define PSWRC_CTRL_SPI4_BIT  3
`define PSWRC_CTRL_PLINK_BIT 4
// ----------------------------------------
// reset values
// ----------------------------------------
`define PSWRC_CTRL_RST       8'h00
`define PSWRC_SBY_SEL_RST    8'h00
`define PSWRC_SEN_EN_RST     8'hFF
// ----------------------------------------
// power state encodings
// ----------------------------------------
`define PSWRC_ST_ACTIVE      2'h0
`define PSWRC_ST_STANDBY     2'h1
`define PSWRC_ST_DEEP        2'h2
`endif

/* logic/pswrc_top.v */
// pswrc_top.v: power state selection, deep sleep wake, wake pin and reset control
// assumes: one 100 MHz clock; reset pin, wake pin and host-link wake arrive asynchronously
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "pswrc_defines.vh"

module pswrc_top #(
   parameter NCH = 8
) (
   input  wire           clk_i,
   input  wire           nrst_i,
   input  wire           ext_rst_i,
   input  wire [7:0]     reg_addr_i,
   input  wire [7:0]     reg_wdata_i,
   input  wire           reg_wr_i,
   input  wire           reg_rd_i,
   output reg  [7:0]     reg_rdata_o,
   input  wire           link_txn_i,
   input  wire [NCH-1:0] touch_det_i,
   input  wire           wake_pin_i,
   output wire           wake_pin_o,
   output wire           wake_pin_oe_o,
   output wire [NCH-1:0] sample_en_o,
   output wire           led_drive_en_o,
   output wire           blk_rst_o,
   output wire [1:0]     pwr_state_o,
   output wire           int_o
);

   // ----------------------------------------
   // reset and input synchronisers
   // ----------------------------------------
   reg [1:0] nrst_sync_q;
   reg [1:0] ext_sync_q;
   reg [1:0] wake_sync_q;
   reg [1:0] txn_sync_q;
   wire      rst_n;
   wire      ext_rst;
   wire      wake_in;
   wire      txn_in;

   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         nrst_sync_q <= 2'h0;
      end else begin
         nrst_sync_q <= {nrst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = nrst_sync_q[1];

   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ext_sync_q  <= 2'h0;
         wake_sync_q <= 2'h0;
         txn_sync_q  <= 2'h0;
      end else begin
         ext_sync_q  <= {ext_sync_q[0], ext_rst_i};
         wake_sync_q <= {wake_sync_q[0], wake_pin_i};
         txn_sync_q  <= {txn_sync_q[0], link_txn_i};
      end
   end
   assign ext_rst = ext_sync_q[1];
   assign wake_in = wake_sync_q[1];
   assign txn_in  = txn_sync_q[1];

   // held reset for every internal block while the pin is high
   assign blk_rst_o = ext_rst;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   wire [7:0]     ctrl_q;
   wire [7:0]     sby_sel_q;
   wire [7:0]     sen_en_q;
   wire [NCH-1:0] touch_q;
   wire [1:0]     state_q;
   wire           wake_q;
   wire           txn_d1_q;
   reg  [7:0]     ctrl_d;
   reg  [7:0]     sby_sel_d;
   reg  [7:0]     sen_en_d;
   reg  [NCH-1:0] touch_d;
   reg  [1:0]     state_d;
   reg            wake_d;
   reg  [NCH-1:0] smp_d;
   reg  [NCH-1:0] nxt_smp;
   wire           lp_bit;
   wire           ds_bit;
   wire           spi4;
   wire           plink;
   wire           txn_rise;
   wire           wake_mon;
   wire           new_touch;
   wire           int_clr;

   assign lp_bit   = ctrl_q[`PSWRC_CTRL_LP_BIT];
   assign ds_bit   = ctrl_q[`PSWRC_CTRL_DS_BIT];
   assign spi4     = ctrl_q[`PSWRC_CTRL_SPI4_BIT];
   assign plink    = ctrl_q[`PSWRC_CTRL_PLINK_BIT];
   assign txn_rise = txn_in & ~txn_d1_q;
   assign wake_mon = (state_q == `PSWRC_ST_DEEP) & ~spi4;
   assign new_touch = |(touch_det_i & smp_d & ~touch_q);
   assign int_clr  = reg_wr_i & (reg_addr_i == `PSWRC_ADDR_CTRL)
                   & ~reg_wdata_i[`PSWRC_CTRL_INT_BIT];

   // ----------------------------------------
   // power state selection
   // ----------------------------------------
   always @* begin
      if (ds_bit & ~plink) begin
         state_d = `PSWRC_ST_DEEP;
      end else if (lp_bit) begin
         state_d = `PSWRC_ST_STANDBY;
      end else begin
         state_d = `PSWRC_ST_ACTIVE;
      end
   end

   // channels sampled per state
   always @* begin
      case (state_q)
         `PSWRC_ST_ACTIVE:  smp_d = sen_en_q[NCH-1:0];
         `PSWRC_ST_STANDBY: smp_d = sby_sel_q[NCH-1:0];
         `PSWRC_ST_DEEP:    smp_d = {NCH{1'b0}};
         default:           smp_d = {NCH{1'b0}};
      endcase
   end

   // ----------------------------------------
   // next values of the registers
   // ----------------------------------------
   // software write first, hardware events after, so the events win
   always @* begin
      ctrl_d = ctrl_q;
      if (reg_wr_i & (reg_addr_i == `PSWRC_ADDR_CTRL)) begin
         ctrl_d = {3'h0, reg_wdata_i[4:0]};
         // int flag is only cleared by software, not set by it
         ctrl_d[`PSWRC_CTRL_INT_BIT] = ctrl_q[`PSWRC_CTRL_INT_BIT]
                                     & reg_wdata_i[`PSWRC_CTRL_INT_BIT];
      end
      // a transaction in deep sleep wakes; it beats a same-cycle write
      if ((state_q == `PSWRC_ST_DEEP) & txn_rise) begin
         ctrl_d[`PSWRC_CTRL_DS_BIT] = 1'b0;
      end
      if (wake_mon & wake_in) begin
         ctrl_d[`PSWRC_CTRL_DS_BIT] = 1'b0;
      end
      // interrupt set wins over a clear in the same cycle
      if (new_touch) begin
         ctrl_d[`PSWRC_CTRL_INT_BIT] = 1'b1;
      end
   end

   always @* begin
      sby_sel_d = sby_sel_q;
      sen_en_d  = sen_en_q;
      if (reg_wr_i & (reg_addr_i == `PSWRC_ADDR_SBY_SEL)) begin
         sby_sel_d = reg_wdata_i;
      end
      if (reg_wr_i & (reg_addr_i == `PSWRC_ADDR_SEN_EN)) begin
         sen_en_d = reg_wdata_i;
      end
   end

   // mask of channels sampled in the next state
   always @* begin
      case (state_d)
         `PSWRC_ST_ACTIVE:  nxt_smp = sen_en_q[NCH-1:0];
         `PSWRC_ST_STANDBY: nxt_smp = sby_sel_q[NCH-1:0];
         default:           nxt_smp = {NCH{1'b0}};
      endcase
   end

   // touches latch until the int clear; a touch still present survives it
   always @* begin
      touch_d = touch_q | (touch_det_i & smp_d);
      if (int_clr) begin
         touch_d = touch_det_i & smp_d;
      end
      // touches of channels not sampled drop on a state change
      if (state_d != state_q) begin
         touch_d = touch_d & nxt_smp;
      end
   end

   // wake output in standby without four-wire mode
   always @* begin
      wake_d = wake_q;
      if ((state_q == `PSWRC_ST_STANDBY) & ~spi4 & new_touch) begin
         wake_d = 1'b1;
      end else if (int_clr | spi4 | (state_q != `PSWRC_ST_STANDBY)) begin
         wake_d = 1'b0;
      end
   end

   // ----------------------------------------
   // state registers
   // ----------------------------------------
   pswrc_dreg #(
      .W   (8),
      .RST (`PSWRC_CTRL_RST)
   ) i_ctrl_reg (
      .clk_i  (clk_i),
      .nrst_i (rst_n),
      .clr_i  (ext_rst),
      .d_i    (ctrl_d),
      .q_o    (ctrl_q)
   );

   pswrc_dreg #(
      .W   (8),
      .RST (`PSWRC_SBY_SEL_RST)
   ) i_sby_sel_reg (
      .clk_i  (clk_i),
      .nrst_i (rst_n),
      .clr_i  (ext_rst),
      .d_i    (sby_sel_d),
      .q_o    (sby_sel_q)
   );

   pswrc_dreg #(
      .W   (8),
      .RST (`PSWRC_SEN_EN_RST)
   ) i_sen_en_reg (
      .clk_i  (clk_i),
      .nrst_i (rst_n),
      .clr_i  (ext_rst),
      .d_i    (sen_en_d),
      .q_o    (sen_en_q)
   );

   pswrc_dreg #(
      .W   (NCH),
      .RST ({NCH{1'b0}})
   ) i_touch_reg (
      .clk_i  (clk_i),
      .nrst_i (rst_n),
      .clr_i  (ext_rst),
      .d_i    (touch_d),
      .q_o    (touch_q)
   );

   pswrc_dreg #(
      .W   (2),
      .RST (`PSWRC_ST_ACTIVE)
   ) i_state_reg (
      .clk_i  (clk_i),
      .nrst_i (rst_n),
      .clr_i  (ext_rst),
      .d_i    (state_d),
      .q_o    (state_q)
   );

   pswrc_dreg #(
      .W   (1),
      .RST (1'b0)
   ) i_wake_reg (
      .clk_i  (clk_i),
      .nrst_i (rst_n),
      .clr_i  (ext_rst),
      .d_i    (wake_d),
      .q_o    (wake_q)
   );

   pswrc_dreg #(
      .W   (1),
      .RST (1'b0)
   ) i_txn_d1_reg (
      .clk_i  (clk_i),
      .nrst_i (rst_n),
      .clr_i  (ext_rst),
      .d_i    (txn_in),
      .q_o    (txn_d1_q)
   );

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign sample_en_o    = ext_rst ? {NCH{1'b0}} : smp_d;
   // led drive is independent of power state, off only during reset
   assign led_drive_en_o = ~ext_rst;
   assign wake_pin_o     = wake_q;
   // drive only in standby; in deep sleep the pin floats as an input
   assign wake_pin_oe_o  = (state_q == `PSWRC_ST_STANDBY) & ~spi4;
   assign pwr_state_o    = state_q;
   assign int_o          = ctrl_q[`PSWRC_CTRL_INT_BIT];

   // ----------------------------------------
   // register read port
   // ----------------------------------------
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i & ~ext_rst) begin
         case (reg_addr_i)
            `PSWRC_ADDR_CTRL:    reg_rdata_o <= ctrl_q;
            `PSWRC_ADDR_STAT:    reg_rdata_o <= {5'h00, wake_q, state_q};
            `PSWRC_ADDR_SBY_SEL: reg_rdata_o <= sby_sel_q;
            `PSWRC_ADDR_SEN_EN:  reg_rdata_o <= sen_en_q;
            `PSWRC_ADDR_TOUCH:   reg_rdata_o <= touch_q;
            default:             reg_rdata_o <= 8'h00;
         endcase
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

endmodule // pswrc_top

// ----------------------------------------
// register with power-on reset and a held clear
// ----------------------------------------
// the clear is synchronous: the reset pin is already synchronised, never a second async reset
module pswrc_dreg #(
   parameter         W   = 1,
   parameter [W-1:0] RST = {W{1'b0}}
) (
   input  wire         clk_i,
   input  wire         nrst_i,
   input  wire         clr_i,
   input  wire [W-1:0] d_i,
   output reg  [W-1:0] q_o
);

   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q_o <= RST;
      end else if (clr_i) begin
         q_o <= RST;
      end else begin
         q_o <= d_i;
      end
   end

endmodule // pswrc_dreg

/* bench/pswrc_top_asserts.sv */
// pswrc_top_asserts.sv: port-level checks of the power state controller
// assumes: bound to pswrc_top; ext reset never raised near nrst_i release
`timescale 1ns/10ps
module pswrc_asserts #(
   parameter NCH = 8
) (
   input wire           clk_i,
   input wire           nrst_i,
   input wire           ext_rst_i,
   input wire           link_txn_i,
   input wire           wake_pin_i,
   input wire           wake_pin_o,
   input wire           wake_pin_oe_o,
   input wire [NCH-1:0] sample_en_o,
   input wire           led_drive_en_o,
   input wire           blk_rst_o,
   input wire [1:0]     pwr_state_o,
   input wire           int_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_deep_pin;
      pwr_state_o == 2'h2 && wake_pin_i;
   endsequence
   sequence s_deep_link;
      pwr_state_o == 2'h2 && $rose(link_txn_i);
   endsequence
   a_state_legal: assert property (pwr_state_o != 2'h3)
      else $error("power state code out of range");
   a_deep_quiet: assert property (pwr_state_o == 2'h2 |-> sample_en_o == 0)
      else $error("channel sampled in deep sleep");
   a_pin_wake: assert property (s_deep_pin |-> ##[1:6] pwr_state_o == 2'h0)
      else $error("wake pin did not end deep sleep");
   a_link_wake: assert property (s_deep_link |-> ##[1:6] pwr_state_o == 2'h0)
      else $error("transaction did not end deep sleep");
   a_rst_sync: assert property (ext_rst_i [*3] |-> blk_rst_o)
      else $error("external reset not passed on");
   a_rst_quiet: assert property (blk_rst_o |-> !led_drive_en_o && sample_en_o == 0)
      else $error("activity during reset");
   a_led_kept: assert property (!blk_rst_o |-> led_drive_en_o)
      else $error("led drive dropped outside reset");
   a_oe_standby: assert property (wake_pin_oe_o |-> pwr_state_o == 2'h1)
      else $error("wake pin driven outside standby");
   a_wake_int: assert property (wake_pin_o |-> int_o)
      else $error("wake output without pending flag");
   a_rst_defaults: assert property ($fell(blk_rst_o) |-> pwr_state_o == 0 && !int_o)
      else $error("state not default after reset");
endmodule // pswrc_asserts

bind pswrc_top pswrc_asserts #(.NCH(NCH)) i_pswrc_asserts (.clk_i, .nrst_i, .ext_rst_i,
   .link_txn_i, .wake_pin_i, .wake_pin_o, .wake_pin_oe_o, .sample_en_o, .led_drive_en_o,
   .blk_rst_o, .pwr_state_o, .int_o);

/* bench/pswrc_host_model.sv */
// pswrc_host_model.sv: host side of the shared wake line, selected by the device output enable
// assumes: the bench asks for a wake pulse through wake_req_i
`timescale 1ns/10ps
module pswrc_host_model (
   input  wire logic wake_req_i,
   input  wire logic dev_wake_i,
   input  wire logic dev_oe_i,
   output wire logic line_o
);
   // host drives only while the device has let go; otherwise the device wake output wins
   assign line_o = dev_oe_i ? dev_wake_i : wake_req_i;
endmodule // pswrc_host_model

/* bench/test_power_state_wake_reset_control.sv */
// test_power_state_wake_reset_control.sv: self-checking bench for pswrc_top
// assumes: 100 MHz clock; host model resolves the wake line
`timescale 1ns/10ps
module test_power_state_wake_reset_control;
   logic        clk_i = 0, nrst_i = 0, ext_rst_i = 0, reg_wr_i = 0, reg_rd_i = 0;
   logic        link_txn_i = 0, host_wake = 0, wake_pin_i, wake_pin_o, wake_pin_oe_o;
   logic        led_drive_en_o, blk_rst_o, int_o;
   logic [1:0]  pwr_state_o;
   logic [7:0]  reg_addr_i = 0, reg_wdata_i = 0, touch_det_i = 0, reg_rdata_o, sample_en_o, rd;
   int          n_errors = 0, n_tests = 0, cyc = 0;
   // ctrl write, expected state, expected sampled channels (standby select 0a)
   logic [23:0] rows [7] = '{24'h00_00ff, 24'h01_010a, 24'h02_0200, 24'h03_0200,
                             24'h12_00ff, 24'h13_010a, 24'h00_00ff};
   pswrc_top #(.NCH(8)) i_pswrc_top (.clk_i, .nrst_i, .ext_rst_i, .reg_addr_i, .reg_wdata_i,
      .reg_wr_i, .reg_rd_i, .reg_rdata_o, .link_txn_i, .touch_det_i, .wake_pin_i, .wake_pin_o,
      .wake_pin_oe_o, .sample_en_o, .led_drive_en_o, .blk_rst_o, .pwr_state_o, .int_o);
   pswrc_host_model i_pswrc_host_model (.wake_req_i(host_wake), .dev_wake_i(wake_pin_o),
      .dev_oe_i(wake_pin_oe_o), .line_o(wake_pin_i));
   initial forever #5 clk_i = ~clk_i;
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk_i);
      reg_wr_i    <= 1;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(posedge clk_i);
      reg_wr_i <= 0;
   endtask
   task automatic rd_reg(logic [7:0] a);
      @(posedge clk_i);
      reg_rd_i   <= 1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_rd_i <= 0;
      #1 rd = reg_rdata_o;
   endtask
   task test_done;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // a hang counts as a mismatch
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_errors++;
         test_done;
      end
   end
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge clk_i);
      nrst_i <= 1;
      tick(3);
      rd_reg(8'h03);
      chk("sensor enable", 8'hff, rd);
      wr(8'h02, 8'h0a);
      foreach (rows[i]) begin
         wr(8'h00, rows[i][23:16]);
         tick(2);
         chk("state", rows[i][15:8], {6'h0, pwr_state_o});
         chk("sampled", rows[i][7:0], sample_en_o);
         chk("led", 8'h01, {7'h0, led_drive_en_o});
         rd_reg(8'h01);
         chk("status", rows[i][15:8], rd);
      end
      // touch on channel 0 while active, then lose it by entering standby
      @(posedge clk_i) touch_det_i <= 8'h01;
      @(posedge clk_i) touch_det_i <= 8'h00;
      rd_reg(8'h04);
      chk("touches", 8'h01, rd);
      wr(8'h00, 8'h01);
      tick(2);
      rd_reg(8'h04);
      chk("touches", 8'h00, rd);
      chk("flags", 8'h00, {6'h0, int_o, wake_pin_o});
      @(posedge clk_i) touch_det_i <= 8'h02;
      @(posedge clk_i) touch_det_i <= 8'h00;
      tick(3);
      chk("wake", 8'h07, {5'h0, wake_pin_oe_o, int_o, wake_pin_o});
      wr(8'h00, 8'h05);
      tick(2);
      chk("wake kept", 8'h03, {6'h0, int_o, wake_pin_o});
      wr(8'h00, 8'h01);
      tick(2);
      chk("wake cleared", 8'h00, {6'h0, int_o, wake_pin_o});
      // deep sleep left by the wake pin, then by a transaction
      for (int k = 0; k < 2; k++) begin
         wr(8'h00, 8'h02);
         tick(2);
         chk("deep", 8'h02, {5'h0, wake_pin_oe_o, pwr_state_o});
         @(posedge clk_i) {host_wake, link_txn_i} <= k ? 2'h1 : 2'h2;
         tick(2);
         @(posedge clk_i) {host_wake, link_txn_i} <= 2'h0;
         tick(4);
         chk("woken", 8'h00, {6'h0, pwr_state_o});
         rd_reg(8'h00);
         chk("ctrl", 8'h00, rd);
      end
      // four-wire mode in standby: flag only, pin neither driven nor raised
      wr(8'h00, 8'h09);
      tick(2);
      @(posedge clk_i) touch_det_i <= 8'h02;
      @(posedge clk_i) touch_det_i <= 8'h00;
      tick(3);
      chk("four-wire", 8'h02, {5'h0, wake_pin_oe_o, int_o, wake_pin_o});
      wr(8'h00, 8'h00);
      wr(8'h03, 8'hfd);
      tick(2);
      chk("sampled", 8'hfd, sample_en_o);
      // external reset from deep sleep with a non-default standby select
      wr(8'h02, 8'h55);
      wr(8'h00, 8'h02);
      @(posedge clk_i) ext_rst_i <= 1;
      tick(4);
      chk("held", 8'h02, {6'h0, blk_rst_o, led_drive_en_o});
      chk("sampled", 8'h00, sample_en_o);
      rd_reg(8'h02);
      chk("read in reset", 8'h00, rd);
      @(posedge clk_i) ext_rst_i <= 0;
      tick(4);
      chk("state", 8'h00, {6'h0, pwr_state_o});
      rd_reg(8'h02);
      chk("standby select", 8'h00, rd);
      rd_reg(8'h03);
      chk("sensor enable", 8'hff, rd);
      rd_reg(8'h40);
      chk("unmapped", 8'h00, rd);
      test_done;
   end
endmodule // test_power_state_wake_reset_control
